// ===== src/tsa_top.sv
// temperature sensor alarm: converter timing, alert logic, bus slave, serial port
`default_nettype none
module tsa_top
  import tsa_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYCLES_DFLT
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic [8:0]  sensor_code,
  input  wire logic        link_clk,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe_n,
  input  wire logic        address_pin_0,
  input  wire logic        address_pin_1,
  input  wire logic        address_pin_2,
  output var  logic        overlimit_alert_out,
  output var  logic        overlimit_alert_oe_n
);

  // ==========================================================================
  // state of the register clock domain
  typedef struct packed {
    logic [31:0] conv_cnt;
    logic        shut;
    logic [15:0] temp;
    logic [7:0]  cfg;
    logic [15:0] hyst;
    logic [15:0] over;
    logic        alert;
    logic        hunt_low;
    logic [2:0]  fault_cnt;
    logic        ahb_sel;
    logic        ahb_wr;
    logic [7:0]  ahb_addr;
    logic [31:0] hrdata;
    logic [2:0]  wr_sync;
    logic [2:0]  rd_sync;
    logic        rd_ack_tgl;
    logic [15:0] rd_data;
    logic        pin_oe_n;
  } tsa_core_type;

  // state of the link clock domain
  typedef struct packed {
    logic [2:0]        scl_s;
    logic [2:0]        sda_s;
    logic [2:0]        strap1;
    logic [2:0]        strap2;
    tsa_i2c_state_type st;
    logic [3:0]        bitc;
    logic [7:0]        sh;
    logic [1:0]        ptr;
    logic              byte_idx;
    logic [15:0]       wbuf;
    logic              wr_tgl;
    logic [1:0]        wr_ptr;
    logic [15:0]       wr_data;
    logic              rd_tgl;
    logic [1:0]        ack_s;
    logic              sda_oe_n;
  } tsa_link_type;

  tsa_core_type r_q;
  tsa_core_type r_d;
  tsa_link_type l_q;
  tsa_link_type l_d;

  // ==========================================================================
  // register clock domain
  always_comb
  begin
    logic        conv_done;
    logic        fire;
    logic        clr_req;
    logic        cond;
    logic        sd_rise;
    logic [8:0]  t9;
    logic [7:0]  new_cfg;
    logic        wr_evt;
    logic        rd_evt;
    logic [15:0] rd_word;
    conv_done = 1'b0;
    fire      = 1'b0;
    clr_req   = 1'b0;
    cond      = 1'b0;
    sd_rise   = 1'b0;
    t9        = r_q.temp[15:TEMP_LSB_POS];
    new_cfg   = r_q.cfg;
    wr_evt    = r_q.wr_sync[2] ^ r_q.wr_sync[1];
    rd_evt    = r_q.rd_sync[2] ^ r_q.rd_sync[1];
    rd_word   = 16'h0000;
    r_d       = r_q;

    r_d.wr_sync = {r_q.wr_sync[1:0], l_q.wr_tgl};
    r_d.rd_sync = {r_q.rd_sync[1:0], l_q.rd_tgl};

    // conversion timer runs from reset with no command
    if (!r_q.shut)
    begin
      if (r_q.conv_cnt == CONV_CYCLES - 1)
      begin
        conv_done  = 1'b1;
        r_d.conv_cnt = 32'h0;
        r_d.temp   = {sensor_code, 7'h00};
        r_d.shut   = r_q.cfg[CFG_SHUTDOWN_BIT];
      end
      else
      begin
        r_d.conv_cnt = r_q.conv_cnt + 32'h1;
      end
    end
    else if (!r_q.cfg[CFG_SHUTDOWN_BIT])
    begin
      r_d.shut     = 1'b0;
      r_d.conv_cnt = 32'h0;
    end

    // fault queue and limit comparison on each new result
    if (conv_done)
    begin
      t9 = sensor_code;
      if (r_q.hunt_low)
        cond = $signed(t9) < $signed(r_q.hyst[15:TEMP_LSB_POS]);
      else
        cond = $signed(t9) > $signed(r_q.over[15:TEMP_LSB_POS]);
      if (cond)
      begin
        if (r_q.fault_cnt + 3'h1 >= tsa_fault_limit(r_q.cfg[CFG_FQ_HI_BIT:CFG_FQ_LO_BIT]))
        begin
          fire          = 1'b1;
          r_d.fault_cnt = 3'h0;
        end
        else
        begin
          r_d.fault_cnt = r_q.fault_cnt + 3'h1;
        end
      end
      else
      begin
        r_d.fault_cnt = 3'h0;
      end
    end

    // bus data phase write
    if (r_q.ahb_sel && r_q.ahb_wr)
    begin
      unique case (r_q.ahb_addr)
        ADDR_CFG:  new_cfg  = hwdata[7:0];
        ADDR_HYST: r_d.hyst = hwdata[15:0];
        ADDR_OVER: r_d.over = hwdata[15:0];
        default:   ;
      endcase
    end

    // serial write arrives by toggle, data held stable by the link side
    if (wr_evt)
    begin
      unique case (l_q.wr_ptr)
        PTR_CFG:  new_cfg  = l_q.wr_data[15:8];
        PTR_HYST: r_d.hyst = l_q.wr_data;
        PTR_OVER: r_d.over = l_q.wr_data;
        default:  ;
      endcase
    end
    r_d.cfg = new_cfg;
    sd_rise = new_cfg[CFG_SHUTDOWN_BIT] & ~r_q.cfg[CFG_SHUTDOWN_BIT];

    // serial read request: answer with the selected word
    if (rd_evt)
    begin
      r_d.rd_data    = tsa_reg_word(l_q.ptr, r_d.temp, r_d.cfg, r_d.hyst, r_d.over);
      r_d.rd_ack_tgl = ~r_q.rd_ack_tgl;
      clr_req        = 1'b1;
    end

    // bus address phase: capture and prepare read data
    r_d.ahb_sel = hsel & htrans[1] & hready;
    r_d.ahb_wr  = hwrite;
    r_d.ahb_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      rd_word = tsa_reg_word(haddr[3:2], r_d.temp, r_d.cfg, r_d.hyst, r_d.over);
      if (haddr[7:0] == ADDR_STATUS)
        r_d.hrdata = {24'h0, r_q.fault_cnt, r_q.shut, r_q.hunt_low, r_q.alert, 2'h0};
      else if (haddr[7:4] == 4'h0)
      begin
        r_d.hrdata = {16'h0, rd_word};
        clr_req    = 1'b1;
      end
      else
        r_d.hrdata = 32'h0;
    end

    // alert state: interrupt mode is cleared by register reads (not status) or shutdown, set wins
    if (r_q.cfg[CFG_INT_MODE_BIT] != new_cfg[CFG_INT_MODE_BIT])
    begin
      r_d.alert     = 1'b0;
      r_d.hunt_low  = 1'b0;
      r_d.fault_cnt = 3'h0;
    end
    else if (r_q.cfg[CFG_INT_MODE_BIT])
    begin
      if (clr_req || sd_rise)
        r_d.alert = 1'b0;
      if (fire)
      begin
        r_d.alert    = 1'b1;
        r_d.hunt_low = ~r_q.hunt_low;
      end
    end
    else if (fire)
    begin
      r_d.alert    = ~r_q.hunt_low;
      r_d.hunt_low = ~r_q.hunt_low;
    end

    // open-drain pin: pulls low when the polarity says so, else released
    r_d.pin_oe_n = ~(r_d.alert ^ r_d.cfg[CFG_POL_BIT]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_q          <= '0;
      r_q.temp     <= TEMP_RESET;
      r_q.cfg      <= CFG_RESET;
      r_q.hyst     <= HYST_RESET;
      r_q.over     <= OVER_RESET;
      r_q.pin_oe_n <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ==========================================================================
  // link clock domain: serial slave port
  always_comb
  begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    scl_rise = l_q.scl_s[1] & ~l_q.scl_s[2];
    scl_fall = ~l_q.scl_s[1] & l_q.scl_s[2];
    start_c  = l_q.scl_s[1] & l_q.sda_s[2] & ~l_q.sda_s[1];
    stop_c   = l_q.scl_s[1] & ~l_q.sda_s[2] & l_q.sda_s[1];
    rx_byte  = {l_q.sh[6:0], l_q.sda_s[1]};
    tx_byte  = l_q.byte_idx ? r_q.rd_data[7:0] : r_q.rd_data[15:8];
    l_d      = l_q;

    l_d.scl_s  = {l_q.scl_s[1:0], scl_in};
    l_d.sda_s  = {l_q.sda_s[1:0], sda_in};
    l_d.strap1 = {address_pin_2, address_pin_1, address_pin_0};
    l_d.strap2 = l_q.strap1;
    l_d.ack_s  = {l_q.ack_s[0], r_q.rd_ack_tgl};

    if (start_c)
    begin
      l_d.st       = ST_ADDR;
      l_d.bitc     = 4'h0;
      l_d.sda_oe_n = 1'b1;
    end
    else if (stop_c)
    begin
      l_d.st       = ST_IDLE;
      l_d.sda_oe_n = 1'b1;
    end
    else
    begin
      unique case (l_q.st)
        ST_IDLE: ;
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            l_d.sh   = rx_byte;
            l_d.bitc = l_q.bitc + 4'h1;
            if (l_q.bitc == 4'h7)
            begin
              l_d.bitc = 4'h0;
              if (l_q.st == ST_ADDR)
              begin
                if (rx_byte[7:1] == {DEV_ADDR_HI, l_q.strap2})
                begin
                  l_d.st       = ST_ACK_ADDR;
                  l_d.byte_idx = 1'b0;
                  if (rx_byte[0])
                    l_d.rd_tgl = ~l_q.rd_tgl;
                end
                else
                  l_d.st = ST_IDLE;
              end
              else if (l_q.st == ST_PTR)
              begin
                l_d.ptr = rx_byte[1:0];
                l_d.st  = ST_ACK_PTR;
              end
              else
              begin
                l_d.st       = ST_ACK_WDATA;
                l_d.byte_idx = ~l_q.byte_idx;
                if (l_q.byte_idx)
                  l_d.wbuf[7:0] = rx_byte;
                else
                  l_d.wbuf[15:8] = rx_byte;
                if (l_q.byte_idx || l_q.ptr == PTR_CFG)
                begin
                  l_d.wr_tgl  = ~l_q.wr_tgl;
                  l_d.wr_ptr  = l_q.ptr;
                  l_d.wr_data = l_q.byte_idx ? {l_q.wbuf[15:8], rx_byte} : {rx_byte, 8'h00};
                  l_d.byte_idx = 1'b0;
                end
              end
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_WDATA:
        begin
          if (scl_fall)
          begin
            if (l_q.sda_oe_n)
              l_d.sda_oe_n = 1'b0;
            else
            begin
              l_d.sda_oe_n = 1'b1;
              l_d.bitc     = 4'h0;
              if (l_q.st == ST_ACK_PTR || l_q.st == ST_ACK_WDATA)
                l_d.st = ST_WDATA;
              else if (!l_q.sh[0])
                l_d.st = ST_PTR;
              else if (l_q.ack_s[1] == l_q.rd_tgl)
              begin
                l_d.sh       = tx_byte;
                l_d.sda_oe_n = tx_byte[7];
                l_d.st       = ST_RDATA;
              end
              else
                l_d.st = ST_IDLE;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (l_q.bitc == 4'h7)
            begin
              l_d.sda_oe_n = 1'b1;
              l_d.st       = ST_ACK_RDATA;
              l_d.byte_idx = ~l_q.byte_idx;
            end
            else
            begin
              l_d.sh       = {l_q.sh[6:0], 1'b0};
              l_d.sda_oe_n = l_q.sh[6];
              l_d.bitc     = l_q.bitc + 4'h1;
            end
          end
        end
        ST_ACK_RDATA:
        begin
          if (scl_rise && l_q.sda_s[1])
            l_d.st = ST_IDLE;
          else if (scl_fall)
          begin
            l_d.sh       = tx_byte;
            l_d.sda_oe_n = tx_byte[7];
            l_d.bitc     = 4'h0;
            l_d.st       = ST_RDATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      l_q          <= '0;
      l_q.scl_s    <= 3'h7;
      l_q.sda_s    <= 3'h7;
      l_q.st       <= ST_IDLE;
      l_q.sda_oe_n <= 1'b1;
    end
    else
    begin
      l_q <= l_d;
    end
  end

  // ==========================================================================
  // outputs
  assign hrdata               = r_q.hrdata;
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign sda_out              = 1'b0;
  assign sda_oe_n             = l_q.sda_oe_n;
  assign overlimit_alert_out  = 1'b0;
  assign overlimit_alert_oe_n = r_q.pin_oe_n;

  logic unused_ok;
  assign unused_ok = ^{haddr[31:8], hsize, hwdata[31:16]};

endmodule
`default_nettype wire

// ===== include/tsa_pkg.sv
// constants, types and helpers shared by the temperature sensor alarm block
`default_nettype none
package tsa_pkg;

  // ==========================================================================
  // clock and conversion timing
  localparam int unsigned HCLK_FREQ_KHZ    = 25000;
  localparam int unsigned CONV_TIME_US     = 100000;
  localparam int unsigned CONV_CYCLES_DFLT = CONV_TIME_US * HCLK_FREQ_KHZ / 1000;

  // ==========================================================================
  // register pointers (serial side) and bus byte addresses
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG  = 2'h1;
  localparam logic [1:0] PTR_HYST = 2'h2;
  localparam logic [1:0] PTR_OVER = 2'h3;
  localparam logic [7:0] ADDR_TEMP   = 8'h00;
  localparam logic [7:0] ADDR_CFG    = 8'h04;
  localparam logic [7:0] ADDR_HYST   = 8'h08;
  localparam logic [7:0] ADDR_OVER   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ==========================================================================
  // configuration field positions and temperature LSB position
  localparam int unsigned CFG_SHUTDOWN_BIT = 0;
  localparam int unsigned CFG_INT_MODE_BIT = 1;
  localparam int unsigned CFG_POL_BIT      = 2;
  localparam int unsigned CFG_FQ_LO_BIT    = 3;
  localparam int unsigned CFG_FQ_HI_BIT    = 4;
  localparam int unsigned TEMP_LSB_POS     = 7;

  // ==========================================================================
  // values after reset
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [15:0] HYST_RESET = 16'h4B00;
  localparam logic [15:0] OVER_RESET = 16'h5000;
  localparam logic [15:0] TEMP_RESET = 16'h0000;

  // upper slave address bits; value is arbitrary
  localparam logic [3:0] DEV_ADDR_HI = 4'hB;

  // ==========================================================================
  // serial port states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
    ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_ACK_RDATA
  } tsa_i2c_state_type;

  // consecutive results needed for fault queue setting
  function automatic logic [2:0] tsa_fault_limit(input logic [1:0] fq);
    unique case (fq)
      2'h0: tsa_fault_limit = 3'h1;
      2'h1: tsa_fault_limit = 3'h2;
      2'h2: tsa_fault_limit = 3'h4;
      2'h3: tsa_fault_limit = 3'h6;
    endcase
  endfunction

  // register word selected by a pointer
  function automatic logic [15:0] tsa_reg_word(input logic [1:0] ptr, input logic [15:0] temp,
                                               input logic [7:0] cfg, input logic [15:0] hyst,
                                               input logic [15:0] over);
    unique case (ptr)
      PTR_TEMP: tsa_reg_word = temp;
      PTR_CFG:  tsa_reg_word = {cfg, cfg};
      PTR_HYST: tsa_reg_word = hyst;
      PTR_OVER: tsa_reg_word = over;
    endcase
  endfunction

endpackage
`default_nettype wire

// ===== tb/tsa_monitor.sv
// concurrent checks on the bus and pin side of the alarm block
`default_nettype none
module tsa_monitor
  import tsa_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sda_out,
  input wire logic        overlimit_alert_out,
  input wire logic        overlimit_alert_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic            wcfg_q, wover_q;
  logic [4:0]      cfg_q;
  logic [15:0]     over_q;
  wire logic       rd = hsel & htrans[1] & hready & !hwrite;
  wire logic       wr = hsel & htrans[1] & hready & hwrite;
  wire logic [7:0] ra = haddr[7:0];
  // ==========================================================================
  // shadow of what the bus wrote
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wcfg_q  <= 1'b0;
      wover_q <= 1'b0;
      cfg_q   <= CFG_RESET[4:0];
      over_q  <= OVER_RESET;
    end
    else
    begin
      wcfg_q  <= wr & (ra == ADDR_CFG);
      wover_q <= wr & (ra == ADDR_OVER);
      if (wcfg_q)
        cfg_q <= hwdata[4:0];
      if (wover_q)
        over_q <= hwdata[15:0];
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not ready or not okay");
  property p_alert_od;
    !overlimit_alert_out;
  endproperty
  a_alert_od: assert property (p_alert_od)
    else $error("alert pin driven high");
  property p_sda_od;
    !sda_out;
  endproperty
  a_sda_od: assert property (p_sda_od)
    else $error("serial data driven high");
  property p_temp_fmt;
    rd && ra == ADDR_TEMP |=> hrdata[6:0] == 7'h00 && hrdata[31:16] == 16'h0000;
  endproperty
  a_temp_fmt: assert property (p_temp_fmt)
    else $error("temperature word has stray bits");
  property p_rdata_hold;
    !rd |=> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_cfg_rd;
    rd && ra == ADDR_CFG |=> hrdata[4:0] == cfg_q;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd)
    else $error("configuration read back wrong");
  property p_over_rd;
    rd && ra == ADDR_OVER |=> hrdata[15:0] == over_q;
  endproperty
  a_over_rd: assert property (p_over_rd)
    else $error("over limit read back wrong");
  property p_read_clear;
    rd && ra < ADDR_STATUS && cfg_q[CFG_INT_MODE_BIT] && !cfg_q[CFG_POL_BIT]
      |-> ##[1:3] overlimit_alert_oe_n;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("interrupt alert not cleared by read");
endmodule
`default_nettype wire

// ===== tb/tsa_i2c_master.sv
// behavioural two-wire bus master facing the alarm block
`default_nettype none
module tsa_i2c_master
(
  output var  logic scl,
  output var  logic sda_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // a quarter of a 2.5 us bit keeps the clock at 400 kHz
  localparam time QTR = 625;
  initial
  begin
    scl   = 1'b1;
    sda_o = 1'b1;
  end
  task automatic bit_tx(input logic b);
    sda_o = b;
    #QTR scl = 1'b1;
    #(2 * QTR) scl = 1'b0;
    #QTR;
  endtask
  task automatic bit_rx(output logic b);
    sda_o = 1'b1;
    #QTR scl = 1'b1;
    #QTR b = sda_i;
    #QTR scl = 1'b0;
    #QTR;
  endtask
  task automatic start();
    sda_o = 1'b0;
    #QTR scl = 1'b0;
    #QTR;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_o = 1'b1;
    #(2 * QTR);
  endtask
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_tx(d[i]);
    bit_rx(ack);
  endtask
  task automatic byte_rx(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_rx(d[i]);
    bit_tx(last);
  endtask
endmodule
`default_nettype wire

// ===== tb/temp_sensor_alarm_i2c_test.sv
// self-checking bench for the temperature sensor alarm block
`default_nettype none
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module temp_sensor_alarm_i2c_test
  import tsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CONV = 50;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, link_clk, scl, sda_m;
  logic        sda_out, sda_oe_n, overlimit_alert_out, overlimit_alert_oe_n, ack;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, strap;
  logic [8:0]  sensor_code, code;
  logic [7:0]  msb, lsb;
  logic [6:0]  dev;
  integer      seed;
  int          checked, miscompares, cyc, nf;
  wire logic   sda_w   = sda_m & (sda_oe_n | sda_out);
  wire logic   alert_n = overlimit_alert_oe_n | overlimit_alert_out;
  tsa_top #(.CONV_CYCLES(CONV)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sensor_code(sensor_code),
    .link_clk(link_clk), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .address_pin_0(strap[0]), .address_pin_1(strap[1]),
    .address_pin_2(strap[2]), .overlimit_alert_out(overlimit_alert_out),
    .overlimit_alert_oe_n(overlimit_alert_oe_n));
  tsa_i2c_master i_master (.scl(scl), .sda_o(sda_m), .sda_i(sda_w));
  always #20 hclk = ~hclk;
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #6 link_clk = ~link_clk;
  end
  // ==========================================================================
  // expectations and bus helpers
  function automatic logic [31:0] temp_word(input logic [8:0] c);
    return {16'h0000, c, 7'h00};
  endfunction
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge hclk);
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, $random(seed), rd);
    `CHK(rd, exp)
  endtask
  task automatic settle_alert(input logic lvl);
    @(negedge hclk);
    `CHK(alert_n, lvl)
  endtask
  task automatic wait_alert(input logic lvl);
    cyc = 0;
    do
    begin
      @(negedge hclk);
      cyc++;
    end
    while (alert_n !== lvl && cyc < 8 * CONV);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #3ms;
    miscompares++;
    conclude();
  end
  // ==========================================================================
  // main sequence
  initial
  begin
    seed = 32'hC2B35EC0;
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    strap = 3'($random(seed));
    code = 9'($unsigned($random(seed)) % 32'h90);
    sensor_code = code;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(ADDR_TEMP, {16'h0000, TEMP_RESET});
    rd_chk(ADDR_CFG, {16'h0000, CFG_RESET, CFG_RESET});
    rd_chk(ADDR_HYST, {16'h0000, HYST_RESET});
    rd_chk(ADDR_OVER, {16'h0000, OVER_RESET});
    settle_alert(1'b1);
    repeat (CONV + 5) @(posedge hclk);
    rd_chk(ADDR_TEMP, temp_word(code));
    code = 9'h1F3;
    sensor_code <= code;
    repeat (CONV + 5) @(posedge hclk);
    rd_chk(ADDR_TEMP, temp_word(code));
    ahb(1'b1, ADDR_TEMP, 32'hFFFFFFFF, rd);
    rd_chk(ADDR_TEMP, temp_word(code));
    rd_chk(8'h14, 32'h00000000);
    repeat (4)
    begin
      hwdata <= 32'h00000000;
      rd = $random(seed);
      ahb(1'b1, ADDR_OVER, rd, rd);
      rd_chk(ADDR_OVER, {16'h0000, hwdata[15:0]});
    end
    ahb(1'b1, ADDR_OVER, {16'h0000, OVER_RESET}, rd);
    for (int f = 0; f < 4; f++)
    begin
      nf = (f == 3) ? 6 : (1 << f);
      ahb(1'b1, ADDR_CFG, 32'(f << CFG_FQ_LO_BIT), rd);
      sensor_code <= 9'($unsigned($random(seed)) % 32'h90);
      repeat (7 * CONV) @(posedge hclk);
      settle_alert(1'b1);
      @(posedge hclk);
      sensor_code <= 9'h0A1 + 9'($unsigned($random(seed)) % 32'h40);
      wait_alert(1'b0);
      `CHK(cyc > (nf - 1) * CONV && cyc <= nf * CONV + 5, 1'b1)
      @(posedge hclk);
      sensor_code <= 9'($unsigned($random(seed)) % 32'h90);
      wait_alert(1'b1);
      `CHK(cyc > (nf - 1) * CONV && cyc <= nf * CONV + 5, 1'b1)
    end
    @(posedge hclk);
    sensor_code <= 9'h09B;
    ahb(1'b1, ADDR_CFG, 32'h0000000A, rd);
    repeat (3 * CONV) @(posedge hclk);
    settle_alert(1'b1);
    @(posedge hclk);
    sensor_code <= 9'h0C0;
    wait_alert(1'b0);
    `CHK(cyc > CONV && cyc <= 2 * CONV + 5, 1'b1)
    repeat (3 * CONV) @(posedge hclk);
    settle_alert(1'b0);
    rd_chk(ADDR_STATUS, 32'h0000000C);
    settle_alert(1'b0);
    rd_chk(ADDR_TEMP, temp_word(9'h0C0));
    repeat (3) @(posedge hclk);
    settle_alert(1'b1);
    repeat (3 * CONV) @(posedge hclk);
    settle_alert(1'b1);
    @(posedge hclk);
    sensor_code <= 9'h010;
    wait_alert(1'b0);
    `CHK(cyc > CONV && cyc <= 2 * CONV + 5, 1'b1)
    ahb(1'b1, ADDR_CFG, 32'h0000000B, rd);
    repeat (3) @(posedge hclk);
    settle_alert(1'b1);
    ahb(1'b1, ADDR_CFG, 32'h00000004, rd);
    settle_alert(1'b0);
    ahb(1'b1, ADDR_CFG, 32'h00000000, rd);
    code = 9'($unsigned($random(seed)) % 32'h90);
    sensor_code <= code;
    repeat (2 * CONV + 5) @(posedge hclk);
    dev = {DEV_ADDR_HI, strap};
    i_master.start();
    i_master.byte_tx({dev, 1'b0}, ack);
    `CHK(ack, 1'b0)
    i_master.byte_tx({6'h00, PTR_HYST}, ack);
    i_master.byte_tx(8'h4C, ack);
    i_master.byte_tx(8'h80, ack);
    i_master.stop();
    `CHK(ack, 1'b0)
    rd_chk(ADDR_HYST, 32'h00004C80);
    i_master.start();
    i_master.byte_tx({dev, 1'b0}, ack);
    i_master.byte_tx({6'h00, PTR_TEMP}, ack);
    i_master.stop();
    i_master.start();
    i_master.byte_tx({dev, 1'b1}, ack);
    i_master.byte_rx(1'b0, msb);
    i_master.byte_rx(1'b1, lsb);
    i_master.stop();
    `CHK({16'h0000, msb, lsb}, temp_word(code))
    for (int i = 0; i < 4; i++)
    begin
      i_master.start();
      i_master.byte_tx({dev ^ (7'h01 << i), 1'b0}, ack);
      i_master.stop();
      `CHK(ack, 1'b1)
    end
    conclude();
  end
endmodule
bind tsa_top tsa_monitor i_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sda_out(sda_out),
  .overlimit_alert_out(overlimit_alert_out), .overlimit_alert_oe_n(overlimit_alert_oe_n));
`default_nettype wire
